//--- rtl/adc_result_regs.sv
// Slot-7 result, priority result and monitor 0 threshold registers on AHB-Lite.
// Assumes the conversion engine and the bus share mclk_i; no synchronisers needed.
`timescale 1ns/1ps
`include "adc_result_params.svh"

module adc_result_regs (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// Conversion engine
	input wire logic slot7_store_i,
	input wire logic [9:0] slot7_data_i,
	input wire logic priority_store_i,
	input wire logic [9:0] priority_data_i,
	// Interrupts
	output logic monitor0_interrupt_o,
	output logic irq_o
);

	adc_result_pkg::regs_state_t s;
	adc_result_pkg::regs_state_t next_s;

	logic take;
	logic rd;
	logic [7:0] addr;
	logic rd_slot7;
	logic rd_prio;
	logic rd_status;
	logic wr_phase;
	logic sel_store;
	logic [9:0] sel_value;
	logic hit;

	// Address phase decode
	assign take = hsel_i && htrans_i[1] && hready_i;
	assign rd = take && !hwrite_i;
	assign addr = haddr_i[7:0];
	assign rd_slot7 = rd && (addr == `ADC_ADDR_SLOT7);
	assign rd_prio = rd && (addr == `ADC_ADDR_PRIO);
	assign rd_status = rd && (addr == `ADC_ADDR_STATUS);
	assign wr_phase = (s.phase == adc_result_pkg::BUS_WRITE);

	// Monitor 0 source and comparison
	assign sel_store = s.mon_sel ? priority_store_i : slot7_store_i;
	assign sel_value = s.mon_sel ? priority_data_i : slot7_data_i;
	assign hit = s.mon_en && sel_store &&
		(s.mon_dir ? (sel_value > s.threshold) : (sel_value < s.threshold));

	// Read data layout for one register
	function automatic logic [31:0] read_word(input logic [7:0] a,
		input adc_result_pkg::regs_state_t st);
		logic [31:0] w;
		w = `ADC_RDATA_RESET;
		case (a)
			`ADC_ADDR_SLOT7: begin
				w[`ADC_VALUE_MSB:`ADC_VALUE_LSB] = st.slot7_value;
				w[`ADC_OVR_BIT] = st.slot7_ovr;
				w[`ADC_STORED_BIT] = st.slot7_stored;
			end
			`ADC_ADDR_PRIO: begin
				w[`ADC_VALUE_MSB:`ADC_VALUE_LSB] = st.prio_value;
				w[`ADC_OVR_BIT] = st.prio_ovr;
				w[`ADC_STORED_BIT] = st.prio_stored;
			end
			`ADC_ADDR_THRESH: begin
				w[`ADC_VALUE_MSB:`ADC_VALUE_LSB] = st.threshold;
			end
			`ADC_ADDR_MODE: begin
				w[`ADC_MODE_EN_BIT] = st.mon_en;
				w[`ADC_MODE_DIR_BIT] = st.mon_dir;
				w[`ADC_MODE_SEL_BIT] = st.mon_sel;
			end
			`ADC_ADDR_STATUS: begin
				w[`ADC_MON0_EVT_BIT] = st.int_status;
			end
			`ADC_ADDR_MASK: begin
				w[`ADC_MON0_EVT_BIT] = st.int_mask;
			end
			default: begin
				w = `ADC_RDATA_RESET;
			end
		endcase
		return w;
	endfunction : read_word

	// Next state of the whole block
	always_comb begin
		next_s = s;
		next_s.mon_pulse = 1'b0;
		next_s.hreadyout = 1'b1;
		next_s.hresp = 1'b0;
		// Data phase of a write
		if (wr_phase) begin
			case (s.wr_addr)
				`ADC_ADDR_THRESH: begin
					next_s.threshold = hwdata_i[`ADC_VALUE_MSB:`ADC_VALUE_LSB];
				end
				`ADC_ADDR_MODE: begin
					next_s.mon_en = hwdata_i[`ADC_MODE_EN_BIT];
					next_s.mon_dir = hwdata_i[`ADC_MODE_DIR_BIT];
					next_s.mon_sel = hwdata_i[`ADC_MODE_SEL_BIT];
				end
				`ADC_ADDR_MASK: begin
					next_s.int_mask = hwdata_i[`ADC_MON0_EVT_BIT];
				end
				default: begin
					next_s.phase = s.phase;
				end
			endcase
		end
		// Capture address phase
		next_s.phase = (take && hwrite_i) ? adc_result_pkg::BUS_WRITE
			: adc_result_pkg::BUS_IDLE;
		next_s.wr_addr = addr;
		// Read data for the coming data phase
		next_s.hrdata = rd ? read_word(addr, s) : `ADC_RDATA_RESET;
		if (rd_slot7) begin
			next_s.slot7_ovr = 1'b0;
			next_s.slot7_stored = 1'b0;
		end
		if (rd_prio) begin
			next_s.prio_ovr = 1'b0;
			next_s.prio_stored = 1'b0;
		end
		// Status clears on read
		if (rd_status) begin
			next_s.int_status = 1'b0;
		end
		if (slot7_store_i) begin
			next_s.slot7_value = slot7_data_i;
			next_s.slot7_stored = 1'b1;
			if (s.slot7_stored && !rd_slot7) begin
				next_s.slot7_ovr = 1'b1;
			end
		end
		if (priority_store_i) begin
			next_s.prio_value = priority_data_i;
			next_s.prio_stored = 1'b1;
			if (s.prio_stored && !rd_prio) begin
				next_s.prio_ovr = 1'b1;
			end
		end
		if (hit) begin
			next_s.int_status = 1'b1;
			next_s.mon_pulse = 1'b1;
		end
		next_s.irq = next_s.int_status && next_s.int_mask;
	end

	// State register
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			s <= '0;
			s.hreadyout <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from the state flops
	assign hrdata_o = s.hrdata;
	assign hreadyout_o = s.hreadyout;
	assign hresp_o = s.hresp;
	assign monitor0_interrupt_o = s.mon_pulse;
	assign irq_o = s.irq;

	// Checks on the register behaviour
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);

	property p_slot7_layout;
		rd_slot7 |=> (hrdata_o[31:16] == 16'h0000) && (hrdata_o[5:2] == 4'h0)
			&& (hrdata_o[15:6] == $past(s.slot7_value));
	endproperty
	a_slot7_layout: assert property (p_slot7_layout)
		else $error("slot-7 read layout wrong");

	property p_slot7_overrun;
		slot7_store_i && s.slot7_stored && !rd_slot7 |=> s.slot7_ovr ##1 s.slot7_ovr || $past(rd_slot7);
	endproperty
	a_slot7_overrun: assert property (p_slot7_overrun)
		else $error("slot-7 overrun not set");

	property p_prio_store;
		priority_store_i |=> (s.prio_value == $past(priority_data_i)) && s.prio_stored;
	endproperty
	a_prio_store: assert property (p_prio_store)
		else $error("priority result not stored");

	property p_prio_overrun;
		priority_store_i && s.prio_stored && !rd_prio |=> s.prio_ovr;
	endproperty
	a_prio_overrun: assert property (p_prio_overrun)
		else $error("priority overrun not set");

	property p_slot7_stored;
		slot7_store_i |=> s.slot7_stored && (hrdata_o == 32'h00000000 || $past(rd));
	endproperty
	a_slot7_stored: assert property (p_slot7_stored)
		else $error("slot-7 stored flag not set");

	property p_read_clears;
		(rd_slot7 && !slot7_store_i) || (rd_prio && !priority_store_i)
			|=> ($past(rd_slot7) ? !s.slot7_stored && !s.slot7_ovr
			: !s.prio_stored && !s.prio_ovr);
	endproperty
	a_read_clears: assert property (p_read_clears)
		else $error("read did not clear flags");

	property p_thresh_read;
		rd && (addr == `ADC_ADDR_THRESH)
			|=> hrdata_o == {16'h0000, $past(s.threshold), 6'h00};
	endproperty
	a_thresh_read: assert property (p_thresh_read)
		else $error("threshold read layout wrong");

	property p_mon_disabled;
		!s.mon_en |=> !monitor0_interrupt_o;
	endproperty
	a_mon_disabled: assert property (p_mon_disabled)
		else $error("monitor fired while disabled");

	property p_mon_hit;
		hit |=> monitor0_interrupt_o ##1 (s.int_status || $past(rd_status));
	endproperty
	a_mon_hit: assert property (p_mon_hit)
		else $error("monitor compare missed");

	property p_result_write_ignored;
		wr_phase && (s.wr_addr == `ADC_ADDR_SLOT7) && !slot7_store_i
			|=> $stable(s.slot7_value);
	endproperty
	a_result_write_ignored: assert property (p_result_write_ignored)
		else $error("result register took a write");

	property p_irq_level;
		s.int_status && s.int_mask && !rd_status && !wr_phase |=> irq_o;
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("interrupt not raised");

	property p_prio_layout;
		rd_prio |=> (hrdata_o[31:16] == 16'h0000) && (hrdata_o[5:2] == 4'h0)
			&& (hrdata_o[15:6] == $past(s.prio_value));
	endproperty
	a_prio_layout: assert property (p_prio_layout)
		else $error("priority read layout wrong");

	property p_thresh_write;
		wr_phase && (s.wr_addr == `ADC_ADDR_THRESH)
			|=> s.threshold == $past(hwdata_i[`ADC_VALUE_MSB:`ADC_VALUE_LSB]);
	endproperty
	a_thresh_write: assert property (p_thresh_write)
		else $error("threshold write not taken");

	property p_mon_above;
		s.mon_en && s.mon_dir && !s.mon_sel && slot7_store_i
			&& (slot7_data_i > s.threshold) |=> monitor0_interrupt_o && s.int_status;
	endproperty
	a_mon_above: assert property (p_mon_above)
		else $error("above-threshold result not flagged");

	property p_mon_below;
		s.mon_en && !s.mon_dir && s.mon_sel && priority_store_i
			&& (priority_data_i < s.threshold) |=> monitor0_interrupt_o && s.int_status;
	endproperty
	a_mon_below: assert property (p_mon_below)
		else $error("below-threshold result not flagged");

endmodule : adc_result_regs

//--- inc/adc_result_params.svh
// Offsets, field positions, reset values for the result and compare registers.
// Assumes a 32-bit bus whose byte address low bits select one word register.
`ifndef ADC_RESULT_PARAMS_SVH
`define ADC_RESULT_PARAMS_SVH

// Register byte offsets
`define ADC_ADDR_SLOT7 8'h00
`define ADC_ADDR_PRIO 8'h04
`define ADC_ADDR_THRESH 8'h08
`define ADC_ADDR_MODE 8'h0C
`define ADC_ADDR_STATUS 8'h10
`define ADC_ADDR_MASK 8'h14

// Field positions
`define ADC_VALUE_MSB 15
`define ADC_VALUE_LSB 6
`define ADC_OVR_BIT 1
`define ADC_STORED_BIT 0
`define ADC_MODE_EN_BIT 0
`define ADC_MODE_DIR_BIT 1
`define ADC_MODE_SEL_BIT 2
`define ADC_MON0_EVT_BIT 0

// Reset values
`define ADC_VALUE_RESET 10'h000
`define ADC_RDATA_RESET 32'h00000000

`endif

//--- inc/adc_result_pkg.sv
// Types for the result and compare register block.
// Assumes the constants header supplies offsets and field positions.
package adc_result_pkg;

	// Bus phase, Gray ordered
	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_WRITE = 1'b1
	} bus_phase_t;

	// Whole state of the block
	typedef struct packed {
		bus_phase_t phase;
		logic [7:0] wr_addr;
		logic [9:0] slot7_value;
		logic slot7_ovr;
		logic slot7_stored;
		logic [9:0] prio_value;
		logic prio_ovr;
		logic prio_stored;
		logic [9:0] threshold;
		logic mon_en;
		logic mon_dir;
		logic mon_sel;
		logic int_status;
		logic int_mask;
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
		logic irq;
		logic mon_pulse;
	} regs_state_t;

endpackage : adc_result_pkg

//--- verification/adc_result_and_compare_regs_tb.sv
// Self-checking bench for the slot-7, priority and monitor 0 registers.
// Assumes the bench is the only bus master and plays the conversion engine.
`timescale 1ns/1ps
`include "adc_result_params.svh"
module adc_result_and_compare_regs_tb;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic hsel_i = 1'b0;
	logic [31:0] haddr_i = 32'h0;
	logic [1:0] htrans_i = 2'h0;
	logic hwrite_i = 1'b0;
	logic [31:0] hwdata_i = 32'h0;
	logic [31:0] hrdata_o;
	logic hreadyout_o;
	logic hresp_o;
	logic slot7_store_i = 1'b0;
	logic priority_store_i = 1'b0;
	logic [9:0] slot7_data_i = 10'h0;
	logic [9:0] priority_data_i = 10'h0;
	logic monitor0_interrupt_o;
	logic irq_o;
	logic [31:0] seen;
	logic rdy_s;
	logic [31:0] r;
	logic m;
	logic q;
	int mismatches = 0;
	int compares = 0;
	typedef struct {logic p; logic [9:0] d; logic [31:0] e;} row_t;
	row_t rows [4] = '{'{1'b0, 10'h3FF, 32'h0000FFC1}, '{1'b1, 10'h001, 32'h00000041},
		'{1'b0, 10'h2AA, 32'h0000AA81}, '{1'b1, 10'h155, 32'h00005541}};

	// Clock
	always #20 mclk_i = ~mclk_i;

	// Bus samples as the master sees them at the edge
	always @(posedge mclk_i) begin
		seen <= hrdata_o;
		rdy_s <= hreadyout_o;
	end

	adc_result_regs u_adc_result_regs (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.hsel_i(hsel_i),
		.haddr_i(haddr_i),
		.htrans_i(htrans_i),
		.hwrite_i(hwrite_i),
		.hsize_i(3'h2),
		.hwdata_i(hwdata_i),
		.hready_i(hreadyout_o),
		.hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o),
		.hresp_o(hresp_o),
		.slot7_store_i(slot7_store_i),
		.slot7_data_i(slot7_data_i),
		.priority_store_i(priority_store_i),
		.priority_data_i(priority_data_i),
		.monitor0_interrupt_o(monitor0_interrupt_o),
		.irq_o(irq_o)
	);

	// Verdict and end of run
	task automatic complete_run;
		$display("Compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : complete_run

	// Compare seen against expected
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Wait for hready high at an edge, bounded
	task automatic rdy;
		int n;
		n = 0;
		do begin
			@(posedge mclk_i);
			#1;
			n++;
		end while (rdy_s !== 1'b1 && n < 20);
		if (rdy_s !== 1'b1) begin
			mismatches++;
			complete_run();
		end
	endtask : rdy

	// One single word transfer, read data taken at the data-phase edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		haddr_i <= {24'h0, a};
		hwrite_i <= w;
		rdy();
		htrans_i <= 2'h0;
		hwdata_i <= d;
		rdy();
		r = seen;
	endtask : bus

	// One store pulse; monitor pulse and irq looked at in the next cycle
	task automatic st(input logic p, input logic [9:0] d);
		slot7_store_i <= !p;
		priority_store_i <= p;
		slot7_data_i <= d;
		priority_data_i <= d;
		@(posedge mclk_i);
		slot7_store_i <= 1'b0;
		priority_store_i <= 1'b0;
		#1;
		m = monitor0_interrupt_o;
		q = irq_o;
	endtask : st

	function automatic logic [31:0] res(input logic [9:0] d, input logic [1:0] f);
		return {16'h0, d, 4'h0, f};
	endfunction : res

	function automatic logic [7:0] ad(input logic p);
		return p ? `ADC_ADDR_PRIO : `ADC_ADDR_SLOT7;
	endfunction : ad

	// Every output and register word at its reset value
	task automatic chk_reset;
		chk({29'h0, hresp_o, irq_o, monitor0_interrupt_o}, 32'h0);
		chk({31'h0, hreadyout_o}, 32'h1);
		for (int a = 0; a < 24; a += 4) begin
			bus(1'b0, 8'(a), 32'h0);
			chk(r, 32'h0);
		end
	endtask : chk_reset

	// Main sequence: reset, table rows, then awkward cases
	initial begin
		repeat (20) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		#1;
		chk_reset();
		foreach (rows[i]) begin
			st(rows[i].p, rows[i].d);
			chk({31'h0, m}, 32'h0);
			bus(1'b0, ad(rows[i].p), 32'h0);
			chk(r, rows[i].e);
			bus(1'b0, ad(rows[i].p), 32'h0);
			chk(r, res(rows[i].d, 2'h0));
		end
		// Unread overwrite, then a write that must not land
		for (int p = 0; p < 2; p++) begin
			st(p[0], 10'h011);
			st(p[0], 10'h122);
			bus(1'b0, ad(p[0]), 32'h0);
			chk(r, res(10'h122, 2'h3));
			bus(1'b1, ad(p[0]), 32'hFFFFFFFF);
			bus(1'b0, ad(p[0]), 32'h0);
			chk(r, res(10'h122, 2'h0));
		end
		// Threshold field, reserved bits and an unmapped word
		bus(1'b1, `ADC_ADDR_THRESH, 32'hFFFFFFFF);
		bus(1'b0, `ADC_ADDR_THRESH, 32'h0);
		chk(r, 32'h0000FFC0);
		bus(1'b0, 8'h40, 32'h0);
		chk(r, 32'h0);
		// Threshold set while monitor is still off, then enable above-mode on slot 7
		// written while disabled
		bus(1'b1, `ADC_ADDR_THRESH, res(10'h100, 2'h0));
		bus(1'b1, `ADC_ADDR_MASK, 32'h1);
		bus(1'b1, `ADC_ADDR_MODE, 32'h3);
		st(1'b0, 10'h101);
		chk({30'h0, m, q}, 32'h3);
		st(1'b0, 10'h100);
		chk({31'h0, m}, 32'h0);
		bus(1'b0, `ADC_ADDR_STATUS, 32'h0);
		chk(r, 32'h1);
		@(posedge mclk_i);
		#1;
		chk({31'h0, irq_o}, 32'h0);
		// Below-mode on the priority source; slot 7 no longer watched
		bus(1'b1, `ADC_ADDR_MODE, 32'h5);
		st(1'b0, 10'h000);
		chk({31'h0, m}, 32'h0);
		bus(1'b1, `ADC_ADDR_MASK, 32'h0);
		st(1'b1, 10'h0FF);
		chk({30'h0, m, q}, 32'h2);
		bus(1'b0, `ADC_ADDR_STATUS, 32'h0);
		chk(r, 32'h1);
		// Reset in mid-run with a result and settings held
		st(1'b0, 10'h2AA);
		rst_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		#1;
		chk_reset();
		complete_run();
	end
endmodule : adc_result_and_compare_regs_tb
